// File: shared/zone_cfg_if.sv
`timescale 1ns/1ps
`include "zone_timing_params.svh"

interface zone_cfg_if;
    logic                      wrEn;
    zone_timing_pkg::zone_idx_t wrZone;
    zone_timing_pkg::zone_cfg_t wrData;
    zone_timing_pkg::zone_idx_t rdZone;
    zone_timing_pkg::zone_cfg_t rdData;

    modport store (input wrEn, input wrZone, input wrData, input rdZone, output rdData);
    modport user  (output wrEn, output wrZone, output wrData, output rdZone, input rdData);
endinterface : zone_cfg_if

// File: shared/zone_timing_params.svh
`ifndef ZONE_TIMING_PARAMS_SVH
`define ZONE_TIMING_PARAMS_SVH

`define ZT_ZONES         8
`define ZT_ZONE_W        3
`define ZT_CFG_W         17
`define ZT_CNT_W         5
`define ZT_WAIT_W        8

`define ZT_LEAD_W        2
`define ZT_ACT_W         3
`define ZT_TRAIL_W       2

`define ZT_RD_LEAD_LSB   0
`define ZT_RD_ACT_LSB    2
`define ZT_RD_TRAIL_LSB  5
`define ZT_WR_LEAD_LSB   7
`define ZT_WR_ACT_LSB    9
`define ZT_WR_TRAIL_LSB  12
`define ZT_DOUBLE_BIT    14
`define ZT_READY_EN_BIT  15
`define ZT_READY_SEL_BIT 16

`define ZT_CFG_RESET     17'h0_7FFF

`endif

// File: shared/zone_timing_pkg.sv
`include "zone_timing_params.svh"

package zone_timing_pkg;

    typedef enum logic [2:0] {
        PH_IDLE,
        PH_ALIGN,
        PH_LEAD,
        PH_ACTIVE,
        PH_TRAIL
    } phase_t;

    typedef logic [`ZT_CFG_W-1:0]  zone_cfg_t;
    typedef logic [`ZT_ZONE_W-1:0] zone_idx_t;

endpackage : zone_timing_pkg

// File: sim/external_zone_access_timing_tb.sv
`timescale 1ns/1ps
`include "zone_timing_params.svh"
module external_zone_access_timing_tb;
    logic                  clk, reset, cfgWrite, halfClockSelect, accessStart, accessWrite, readyIn;
    logic                  rdN, wrN, clkOut, busy, done;
    logic [`ZT_ZONE_W-1:0] cfgZone, accessZone;
    logic [`ZT_CFG_W-1:0]  cfgData;
    logic [`ZT_ZONES-1:0]  csN;
    logic [`ZT_WAIT_W-1:0] waits;
    logic [7:0]            readyDelay;
    int                    errors = 0, check_count = 0, cycles = 0, seed = 82;
    int                    cfgModel [8];

    external_zone_access_timing external_zone_access_timing_i (.clk(clk), .reset(reset), .cfgWrite(cfgWrite),
        .cfgZone(cfgZone), .cfgData(cfgData), .halfClockSelect(halfClockSelect), .accessStart(accessStart),
        .accessWrite(accessWrite), .accessZone(accessZone), .externalReadyIn(readyIn),
        .zoneChipSelectOutN(csN), .readStrobeOutN(rdN), .writeStrobeOutN(wrN), .externalClockOut(clkOut),
        .accessBusy(busy), .accessDone(done), .hardwareWaitStates(waits));
    ready_peripheral_model ready_peripheral_model_i (.clk(clk), .chipSelectN(csN), .readStrobeN(rdN),
        .writeStrobeN(wrN), .readyDelay(readyDelay), .readyOut(readyIn));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic end_of_test();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_of_test

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            end_of_test();
        end
    end

    task automatic check_val(input string what, input int expVal, input logic [31:0] seen);
        check_count++;
        if (seen !== 32'(expVal))
        begin
            errors++;
            $display("[ERR] %s expected %0d seen %0d", what, expVal, seen);
        end
    endtask : check_val

    task automatic do_access(input int zone, input int wr, input int dly);
        int w, d, lead, act, trail, ws, ns, nl, nst, bad;
        w = cfgModel[zone];
        d = w[14] + 1;
        lead = (wr ? w[8:7] : w[1:0]) * d;
        act = (wr ? w[11:9] : w[4:2]) * d + 1;
        trail = (wr ? w[13:12] : w[6:5]) * d;
        ws = w[15] ? dly + (w[16] ? 3 : 1) - act : 0;
        ws = ws < 0 ? 0 : ws;
        {ns, nl, nst, bad} = '0;
        accessStart = 1'b1;
        accessWrite = wr[0];
        accessZone = 3'(zone);
        readyDelay = dly[7:0];
        @(posedge clk);
        #1 accessStart = 1'b0;
        for (int i = 0; i < 300 && done !== 1'b1; i++)
        begin
            @(posedge clk);
            #1;
            if (csN[zone] === 1'b0)
            begin
                bad += (clkOut !== (halfClockSelect && !ns[0])) + (wr ? rdN !== 1'b1 : wrN !== 1'b1);
                if ((wr ? wrN : rdN) === 1'b0)
                    nst++;
                else if (nst == 0)
                    nl++;
                ns++;
            end
            // Stray request while busy must be ignored
            accessStart = (i == 2 && done !== 1'b1);
        end
        check_val("lead", lead, nl);
        check_val("active", act + ws, nst);
        check_val("select", lead + act + ws + trail, ns);
        check_val("waits", ws, waits);
        check_val("clock", 0, bad);
    endtask : do_access

    initial
    begin
        {reset, cfgWrite, halfClockSelect, accessStart, accessWrite} = 5'h10;
        {cfgZone, accessZone, cfgData, readyDelay} = '0;
        foreach (cfgModel[z])
            cfgModel[z] = 32'h0000_7FFF;
        repeat (16) @(posedge clk);
        #1 reset = 1'b0;
        do_access(3, 0, 0);
        do_access(5, 1, 0);
        $display("test reset_word done");
        for (int t = 0; t < 6; t++)
        begin
            halfClockSelect = t[0];
            cfgWrite = 1'b1;
            foreach (cfgModel[z])
            begin
                cfgZone = 3'(z);
                cfgModel[z] = $random(seed) & 32'h0001_FFFF;
                if (cfgModel[z][15])
                    cfgModel[z] |= cfgModel[z][16] ? 32'h0000_0489 : 32'h0000_0285;
                cfgData = 17'(cfgModel[z]);
                @(posedge clk);
                #1;
            end
            cfgWrite = 1'b0;
            repeat (10) do_access($random(seed) & 7, $random(seed) & 1, $random(seed) & 7);
            $display("test round %0d done", t);
        end
        end_of_test();
    end
endmodule : external_zone_access_timing_tb

// File: sim/ready_peripheral_model.sv
`timescale 1ns/1ps
`include "zone_timing_params.svh"
module ready_peripheral_model
(
    input  wire logic                 clk,
    input  wire logic [`ZT_ZONES-1:0] chipSelectN,
    input  wire logic                 readStrobeN,
    input  wire logic                 writeStrobeN,
    input  wire logic [7:0]           readyDelay,
    output logic                      readyOut
);
    logic [7:0] lowCount = 8'h00;
    logic       idleToggle = 1'b0;
    wire        strobeLow = !readStrobeN || !writeStrobeN;

    always @(posedge clk)
    begin
        lowCount <= strobeLow ? lowCount + 8'h01 : 8'h00;
        idleToggle <= !idleToggle;
    end
    // Deselected ready line carries no meaning, so it keeps changing
    assign readyOut = (&chipSelectN) ? idleToggle : (strobeLow && lowCount >= readyDelay);
endmodule : ready_peripheral_model

// File: sim/zone_access_sva.sv
`timescale 1ns/1ps
`include "zone_timing_params.svh"
module zone_access_sva
(
    input wire logic                  clk,
    input wire logic                  reset,
    input wire logic                  accessStart,
    input wire logic                  halfClockSelect,
    input wire logic [`ZT_ZONES-1:0]  zoneChipSelectOutN,
    input wire logic                  readStrobeOutN,
    input wire logic                  writeStrobeOutN,
    input wire logic                  externalClockOut,
    input wire logic                  accessBusy,
    input wire logic                  accessDone,
    input wire logic [`ZT_WAIT_W-1:0] hardwareWaitStates
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    wire strobeLow = !readStrobeOutN || !writeStrobeOutN;

    a_strobe_in_select: assert property (strobeLow |-> zoneChipSelectOutN != '1 && accessBusy)
        else $error("strobe outside access");
    a_one_strobe: assert property (readStrobeOutN || writeStrobeOutN)
        else $error("both strobes low");
    a_one_select: assert property ($onehot0(~zoneChipSelectOutN))
        else $error("several zones selected");
    a_done_closes: assert property (accessDone |-> zoneChipSelectOutN == '1 && !strobeLow && !accessBusy)
        else $error("done with access open");
    a_select_end_done: assert property (!$past(reset) && $rose(&zoneChipSelectOutN) |-> accessDone)
        else $error("select ended without done");
    a_busy_end_done: assert property (!$past(reset) && $fell(accessBusy) |-> accessDone)
        else $error("busy ended without done");
    a_start_select: assert property (accessStart && !accessBusy |=> accessBusy ##[1:2] zoneChipSelectOutN != '1)
        else $error("access did not start");
    a_wait_step: assert property (hardwareWaitStates > $past(hardwareWaitStates) |->
        hardwareWaitStates == $past(hardwareWaitStates) + 8'h01 && $past(strobeLow))
        else $error("wait count outside active");
    a_full_rate_low: assert property (!halfClockSelect |=> !externalClockOut)
        else $error("clock out not low");
    a_half_toggle: assert property (halfClockSelect |=> externalClockOut != $past(externalClockOut))
        else $error("clock out not toggling");
endmodule : zone_access_sva

bind external_zone_access_timing zone_access_sva zone_access_sva_i (.clk(clk), .reset(reset),
    .accessStart(accessStart), .halfClockSelect(halfClockSelect), .zoneChipSelectOutN(zoneChipSelectOutN),
    .readStrobeOutN(readStrobeOutN), .writeStrobeOutN(writeStrobeOutN), .externalClockOut(externalClockOut),
    .accessBusy(accessBusy), .accessDone(accessDone), .hardwareWaitStates(hardwareWaitStates));

// File: src/external_zone_access_timing.sv
`timescale 1ns/1ps
`include "zone_timing_params.svh"

// Operation
// - Every zone access runs lead, then active, then trail.
// - Each chip-select zone has its own timing word, used for its accesses.
// - Read lead lasts the read lead count, doubled when doubling is selected.
// - Read active lasts active count (doubled if selected) plus wait states plus one.
// - Read trail lasts the read trail count, doubled when doubling is selected.
// - Writes use the write counts with the same lead, active and trail formulas.
// - Ready input adds wait states in active; none when ready is ignored.
// - No checking of illegal settings; values are used as programmed.
// - Per zone: ignore ready, sample it synchronously, or sample it asynchronously.
// - Strobes and chip selects change only on rising timing-clock edges.
// - At half-rate external clock, even offsets align rising, odd offsets falling.
module external_zone_access_timing
(
    input  wire logic                      clk,
    input  wire logic                      reset,
    input  wire logic                      cfgWrite,
    input  wire logic [`ZT_ZONE_W-1:0]     cfgZone,
    input  wire logic [`ZT_CFG_W-1:0]      cfgData,
    input  wire logic                      halfClockSelect,
    input  wire logic                      accessStart,
    input  wire logic                      accessWrite,
    input  wire logic [`ZT_ZONE_W-1:0]     accessZone,
    input  wire logic                      externalReadyIn,
    output logic [`ZT_ZONES-1:0]           zoneChipSelectOutN,
    output logic                           readStrobeOutN,
    output logic                           writeStrobeOutN,
    output logic                           externalClockOut,
    output logic                           accessBusy,
    output logic                           accessDone,
    output logic [`ZT_WAIT_W-1:0]          hardwareWaitStates
);

    zone_cfg_if cfg ();

    zone_timing_store u_store
    (
        .clk   (clk),
        .reset (reset),
        .cfg   (cfg.store)
    );

    // Scales a field to timing-clock cycles, doubled when selected
    function automatic logic [`ZT_CNT_W-1:0] scaleCount(input logic [`ZT_ACT_W-1:0] field,
                                                        input logic doubleSel);
        logic [`ZT_CNT_W-1:0] wide;
        wide = {{(`ZT_CNT_W-`ZT_ACT_W){1'b0}}, field};
        scaleCount = doubleSel ? (wide << 1) : wide;
    endfunction : scaleCount

    zone_timing_pkg::phase_t    state_reg;
    zone_timing_pkg::phase_t    state_next;
    logic [`ZT_CNT_W-1:0]       cnt_reg;
    logic [`ZT_CNT_W-1:0]       cnt_next;
    zone_timing_pkg::zone_idx_t reqZone_reg;
    logic                       reqWrite_reg;
    zone_timing_pkg::zone_cfg_t cfgHold_reg;
    logic                       readyMeta_reg;
    logic                       readySync_reg;
    logic [`ZT_WAIT_W-1:0]      wait_next;

    wire zone_timing_pkg::zone_cfg_t cfgNow = (state_reg == zone_timing_pkg::PH_ALIGN) ? cfg.rdData : cfgHold_reg;

    wire [`ZT_ACT_W-1:0] leadField  = reqWrite_reg
        ? {1'b0, cfgNow[`ZT_WR_LEAD_LSB +: `ZT_LEAD_W]}
        : {1'b0, cfgNow[`ZT_RD_LEAD_LSB +: `ZT_LEAD_W]};
    wire [`ZT_ACT_W-1:0] actField   = reqWrite_reg
        ? cfgNow[`ZT_WR_ACT_LSB +: `ZT_ACT_W]
        : cfgNow[`ZT_RD_ACT_LSB +: `ZT_ACT_W];
    wire [`ZT_ACT_W-1:0] trailField = reqWrite_reg
        ? {1'b0, cfgNow[`ZT_WR_TRAIL_LSB +: `ZT_TRAIL_W]}
        : {1'b0, cfgNow[`ZT_RD_TRAIL_LSB +: `ZT_TRAIL_W]};
    wire doubleSel = cfgNow[`ZT_DOUBLE_BIT];
    wire readyEn   = cfgNow[`ZT_READY_EN_BIT];
    wire readySel  = cfgNow[`ZT_READY_SEL_BIT];

    wire [`ZT_CNT_W-1:0] leadLen   = scaleCount(leadField, doubleSel);
    wire [`ZT_CNT_W-1:0] activeLen = scaleCount(actField, doubleSel) + `ZT_CNT_W'(1);
    wire [`ZT_CNT_W-1:0] trailLen  = scaleCount(trailField, doubleSel);

    // Ignore, synchronous sample, or two-flop synchronised sample
    wire readyOk = !readyEn || (readySel ? readySync_reg : externalReadyIn);

    // Half-rate mode starts each access as the external clock rises
    wire aligned = !halfClockSelect || !externalClockOut;

    wire inAccessNext = (state_next == zone_timing_pkg::PH_LEAD)
                     || (state_next == zone_timing_pkg::PH_ACTIVE)
                     || (state_next == zone_timing_pkg::PH_TRAIL);
    wire activeNext   = (state_next == zone_timing_pkg::PH_ACTIVE);
    wire doneNext     = (state_reg != zone_timing_pkg::PH_IDLE) && (state_reg != zone_timing_pkg::PH_ALIGN)
                     && (state_next == zone_timing_pkg::PH_IDLE);

    assign cfg.wrEn   = cfgWrite;
    assign cfg.wrZone = cfgZone;
    assign cfg.wrData = cfgData;
    assign cfg.rdZone = (state_reg == zone_timing_pkg::PH_IDLE) ? accessZone : reqZone_reg;

    always_comb
    begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        wait_next  = hardwareWaitStates;
        case (state_reg)
            zone_timing_pkg::PH_IDLE:
            begin
                if (accessStart)
                    state_next = zone_timing_pkg::PH_ALIGN;
            end
            zone_timing_pkg::PH_ALIGN:
            begin
                wait_next = '0;
                if (aligned)
                begin
                    if (leadLen != '0)
                    begin
                        state_next = zone_timing_pkg::PH_LEAD;
                        cnt_next   = leadLen;
                    end
                    else
                    begin
                        state_next = zone_timing_pkg::PH_ACTIVE;
                        cnt_next   = activeLen;
                    end
                end
            end
            zone_timing_pkg::PH_LEAD:
            begin
                if (cnt_reg <= `ZT_CNT_W'(1))
                begin
                    state_next = zone_timing_pkg::PH_ACTIVE;
                    cnt_next   = activeLen;
                end
                else
                    cnt_next = cnt_reg - `ZT_CNT_W'(1);
            end
            zone_timing_pkg::PH_ACTIVE:
            begin
                if (cnt_reg > `ZT_CNT_W'(1))
                    cnt_next = cnt_reg - `ZT_CNT_W'(1);
                else if (!readyOk)
                begin
                    if (hardwareWaitStates != '1)
                        wait_next = hardwareWaitStates + `ZT_WAIT_W'(1);
                end
                else if (trailLen != '0)
                begin
                    state_next = zone_timing_pkg::PH_TRAIL;
                    cnt_next   = trailLen;
                end
                else
                    state_next = zone_timing_pkg::PH_IDLE;
            end
            zone_timing_pkg::PH_TRAIL:
            begin
                if (cnt_reg <= `ZT_CNT_W'(1))
                    state_next = zone_timing_pkg::PH_IDLE;
                else
                    cnt_next = cnt_reg - `ZT_CNT_W'(1);
            end
            default:
            begin
                state_next = zone_timing_pkg::PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_reg          <= zone_timing_pkg::PH_IDLE;
            cnt_reg            <= '0;
            hardwareWaitStates <= '0;
        end
        else
        begin
            state_reg          <= state_next;
            cnt_reg            <= cnt_next;
            hardwareWaitStates <= wait_next;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            reqZone_reg  <= '0;
            reqWrite_reg <= 1'b0;
            cfgHold_reg  <= `ZT_CFG_RESET;
        end
        else if (state_reg == zone_timing_pkg::PH_IDLE && accessStart)
        begin
            reqZone_reg  <= accessZone;
            reqWrite_reg <= accessWrite;
        end
        else if (state_reg == zone_timing_pkg::PH_ALIGN)
            cfgHold_reg <= cfg.rdData;
    end

    // Asynchronous ready path: the first stage feeds only the second
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            readyMeta_reg <= 1'b0;
            readySync_reg <= 1'b0;
        end
        else
        begin
            readyMeta_reg <= externalReadyIn;
            readySync_reg <= readyMeta_reg;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            externalClockOut <= 1'b0;
        else
            externalClockOut <= halfClockSelect ? !externalClockOut : 1'b0;
    end

    // Pin outputs all change on the rising timing-clock edge
    genvar z;
    generate
        for (z = 0; z < `ZT_ZONES; z++)
        begin : g_cs
            always_ff @(posedge clk)
            begin
                if (reset)
                    zoneChipSelectOutN[z] <= 1'b1;
                else
                    zoneChipSelectOutN[z] <= !(inAccessNext && reqZone_reg == `ZT_ZONE_W'(z));
            end
        end
    endgenerate

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            readStrobeOutN  <= 1'b1;
            writeStrobeOutN <= 1'b1;
            accessBusy      <= 1'b0;
            accessDone      <= 1'b0;
        end
        else
        begin
            readStrobeOutN  <= !(activeNext && !reqWrite_reg);
            writeStrobeOutN <= !(activeNext && reqWrite_reg);
            accessBusy      <= state_next != zone_timing_pkg::PH_IDLE;
            accessDone      <= doneNext;
        end
    end

endmodule : external_zone_access_timing

// File: src/zone_timing_store.sv
`timescale 1ns/1ps
`include "zone_timing_params.svh"

module zone_timing_store
(
    input  wire logic clk,
    input  wire logic reset,
    zone_cfg_if.store cfg
);

    zone_timing_pkg::zone_cfg_t entry_reg [`ZT_ZONES];

    // One timing word per zone
    genvar z;
    generate
        for (z = 0; z < `ZT_ZONES; z++)
        begin : g_zone
            always_ff @(posedge clk)
            begin
                if (reset)
                    entry_reg[z] <= `ZT_CFG_RESET;
                else if (cfg.wrEn && (cfg.wrZone == `ZT_ZONE_W'(z)))
                    entry_reg[z] <= cfg.wrData;
            end
        end
    endgenerate

    always_ff @(posedge clk)
    begin
        if (reset)
            cfg.rdData <= `ZT_CFG_RESET;
        else
            cfg.rdData <= entry_reg[cfg.rdZone];
    end

endmodule : zone_timing_store
